// file: rtl/bdcp_core.sv
// bdcp_core: boot command interpreter behind the host register port
// assumes: a serial front end delivers decoded byte reads and writes on clk;
// memory, download hardware and system reset logic sit outside and act on the pulses here
`timescale 1ns/10ps
`default_nettype none

// Function
// - writing command register starts a command; reading gives status, nonzero other than busy (0x01) means error
// - host places payload byte count, at most 0x80, in the length register
// - 128 payload byte registers at consecutive addresses from 0x0A
// - checksum equals inverted 8-bit sum of command, length and payload bytes
// - command 0x11 with no payload remaps program memory and restarts the system
// - remap and restart fires at once after acceptance, no added delay
// - command 0x14 with one seed byte initialises the download hardware
// - command 0x41 copies payload bytes in order to memory at the pointer
// - after a memory write the pointer rests just past the written bytes
// - command 0x43 with two payload bytes loads the memory pointer
// - pointer payload byte zero is the low address byte, byte one the high
// - boot registers exist only while the application identifier is the boot value
module bdcp_core
  import bdcp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // running application identifier
  input wire logic [7:0] appId,
  // host register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // program memory write port
  output logic memWrEn,
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  // download hardware seed
  output logic seedLoad,
  output logic [7:0] seedValue,
  // remap and restart request to the system reset logic
  output logic remapRestart
);

  bdcp_regs_t r_q;
  bdcp_regs_t r_d;
  logic bootMode;
  logic hostWr;

  // decode a register read
  function automatic logic [7:0] readMux(input bdcp_regs_t s, input logic [7:0] a);
    logic [7:0] off;
    off = a - ADDR_PAY_BASE;
    if (a == ADDR_CMD_STAT) begin
      readMux = s.status;
    end else if (a == ADDR_LENGTH) begin
      readMux = s.len;
    end else if (a == ADDR_CHECKSUM) begin
      readMux = s.csum;
    end else if (a >= ADDR_PAY_BASE && a < ADDR_PAY_END) begin
      readMux = s.pay[off[6:0]];
    end else begin
      readMux = RST_BYTE;
    end
  endfunction

  assign bootMode = (appId == BOOT_APP_ID);
  assign hostWr = regWrite && bootMode && (r_q.state == ST_IDLE);

  always_comb begin
    logic [7:0] off;
    off = regAddr - ADDR_PAY_BASE;
    r_d = r_q;
    r_d.memWrEn = 1'b0;
    r_d.seedLoad = 1'b0;
    r_d.remapRestart = 1'b0;
    // reads answer one cycle later; hidden registers read as zero
    if (regRead) begin
      r_d.rdData = bootMode ? readMux(r_q, regAddr) : RST_BYTE;
    end
    unique case (r_q.state)
      ST_IDLE: begin
        if (hostWr) begin
          if (regAddr == ADDR_CMD_STAT) begin
            r_d.cmd = regWrData;
            r_d.status = STAT_BUSY;
            r_d.acc = regWrData + r_q.len;
            r_d.idx = RST_BYTE;
            r_d.state = ST_SUM;
          end else if (regAddr == ADDR_LENGTH) begin
            r_d.len = regWrData;
          end else if (regAddr == ADDR_CHECKSUM) begin
            r_d.csum = regWrData;
          end else if (regAddr >= ADDR_PAY_BASE && regAddr < ADDR_PAY_END) begin
            r_d.pay[off[6:0]] = regWrData;
          end
        end
      end
      ST_SUM: begin
        if (r_q.len > LEN_MAX) begin
          r_d.status = STAT_LEN_ERR;
          r_d.state = ST_IDLE;
        end else if (r_q.idx < r_q.len) begin
          r_d.acc = r_q.acc + r_q.pay[r_q.idx[6:0]];
          r_d.idx = r_q.idx + 8'h01;
        end else if ((r_q.acc ^ CSUM_INVERT) != r_q.csum) begin
          r_d.status = STAT_CSUM_ERR;
          r_d.state = ST_IDLE;
        end else begin
          r_d.state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        r_d.state = ST_IDLE;
        r_d.status = STAT_OK;
        if (r_q.cmd == CMD_REMAP_RESTART) begin
          if (r_q.len == LEN_REMAP) begin
            r_d.remapRestart = 1'b1;
          end else begin
            r_d.status = STAT_LEN_ERR;
          end
        end else if (r_q.cmd == CMD_DOWNLOAD_INIT) begin
          if (r_q.len == LEN_SEED) begin
            r_d.seedLoad = 1'b1;
            r_d.seedValue = r_q.pay[0];
          end else begin
            r_d.status = STAT_LEN_ERR;
          end
        end else if (r_q.cmd == CMD_PTR_SET) begin
          if (r_q.len == LEN_PTR) begin
            r_d.ptr = {r_q.pay[1], r_q.pay[0]};
          end else begin
            r_d.status = STAT_LEN_ERR;
          end
        end else if (r_q.cmd == CMD_MEM_WRITE) begin
          r_d.status = STAT_BUSY;
          r_d.idx = RST_BYTE;
          r_d.state = ST_WRITE;
        end else begin
          r_d.status = STAT_CMD_ERR;
        end
      end
      ST_WRITE: begin
        if (r_q.idx < r_q.len) begin
          r_d.memWrEn = 1'b1;
          r_d.memAddr = r_q.ptr;
          r_d.memWrData = r_q.pay[r_q.idx[6:0]];
          r_d.ptr = r_q.ptr + 16'h0001;
          r_d.idx = r_q.idx + 8'h01;
        end else begin
          r_d.status = STAT_OK;
          r_d.state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign regRdData = r_q.rdData;
  assign memWrEn = r_q.memWrEn;
  assign memAddr = r_q.memAddr;
  assign memWrData = r_q.memWrData;
  assign seedLoad = r_q.seedLoad;
  assign seedValue = r_q.seedValue;
  assign remapRestart = r_q.remapRestart;

  // a command write is reported busy until it finishes
  AST_CMD_BUSY: assert property (@(posedge clk) disable iff (rst)
    hostWr && regAddr == ADDR_CMD_STAT |=> r_q.status == STAT_BUSY && r_q.state == ST_SUM)
    else $error("command write did not start execution");

  AST_LEN_STORE: assert property (@(posedge clk) disable iff (rst)
    hostWr && regAddr == ADDR_LENGTH |=> r_q.len == $past(regWrData))
    else $error("length write not stored");

  AST_PAY_STORE: assert property (@(posedge clk) disable iff (rst)
    hostWr && regAddr == ADDR_PAY_BASE |=> r_q.pay[0] == $past(regWrData))
    else $error("first payload byte not stored");

  AST_CSUM_BAD: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_SUM && r_q.len <= LEN_MAX && r_q.idx >= r_q.len
      && (r_q.acc ^ CSUM_INVERT) != r_q.csum
    |=> r_q.status == STAT_CSUM_ERR && r_q.state == ST_IDLE && !r_q.memWrEn)
    else $error("bad checksum not reported");

  AST_REMAP_NOW: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_EXEC && r_q.cmd == CMD_REMAP_RESTART && r_q.len == LEN_REMAP
    |=> remapRestart ##1 !remapRestart)
    else $error("remap and restart not issued at once");

  AST_SEED_LOAD: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_EXEC && r_q.cmd == CMD_DOWNLOAD_INIT && r_q.len == LEN_SEED
    |=> seedLoad && seedValue == $past(r_q.pay[0]))
    else $error("seed not delivered");

  AST_MEM_BYTE: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_WRITE && r_q.idx < r_q.len
    |=> memWrEn && memAddr == $past(r_q.ptr) && memWrData == $past(r_q.pay[r_q.idx[6:0]]))
    else $error("memory byte wrong");

  AST_PTR_ADVANCE: assert property (@(posedge clk) disable iff (rst)
    memWrEn |-> r_q.ptr == memAddr + 16'h0001)
    else $error("pointer does not follow written bytes");

  AST_PTR_SET: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_EXEC && r_q.cmd == CMD_PTR_SET && r_q.len == LEN_PTR
    |=> r_q.ptr == {$past(r_q.pay[1]), $past(r_q.pay[0])})
    else $error("pointer load byte order wrong");

  AST_HIDDEN: assert property (@(posedge clk) disable iff (rst)
    regRead && !bootMode |=> regRdData == RST_BYTE)
    else $error("registers visible outside boot mode");

  AST_UNKNOWN_CMD: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_EXEC && r_q.cmd != CMD_REMAP_RESTART && r_q.cmd != CMD_DOWNLOAD_INIT
      && r_q.cmd != CMD_MEM_WRITE && r_q.cmd != CMD_PTR_SET
    |=> r_q.status == STAT_CMD_ERR && !memWrEn && !seedLoad && !remapRestart)
    else $error("unknown command not refused");

  AST_CMD_CAPTURE: assert property (@(posedge clk) disable iff (rst)
    hostWr && regAddr == ADDR_CMD_STAT |=> r_q.cmd == $past(regWrData))
    else $error("command code not captured");

  AST_STATUS_READ: assert property (@(posedge clk) disable iff (rst)
    regRead && bootMode && regAddr == ADDR_CMD_STAT |=> regRdData == $past(r_q.status))
    else $error("status read does not return status");

  AST_RUN_BUSY: assert property (@(posedge clk) disable iff (rst)
    r_q.state != ST_IDLE |-> r_q.status == STAT_BUSY)
    else $error("running command not reported busy");

  AST_EXEC_DONE: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_EXEC && r_q.cmd != CMD_MEM_WRITE
    |=> r_q.state == ST_IDLE && r_q.status != STAT_BUSY)
    else $error("command did not finish");

  AST_LEN_LIMIT: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_SUM && r_q.len > LEN_MAX
    |=> r_q.status == STAT_LEN_ERR && r_q.state == ST_IDLE)
    else $error("oversized length accepted");

  AST_PAY_READ: assert property (@(posedge clk) disable iff (rst)
    regRead && bootMode && regAddr == ADDR_PAY_BASE |=> regRdData == $past(r_q.pay[0]))
    else $error("first payload byte not read back");

  AST_CSUM_STORE: assert property (@(posedge clk) disable iff (rst)
    hostWr && regAddr == ADDR_CHECKSUM |=> r_q.csum == $past(regWrData))
    else $error("checksum write not stored");

  AST_SUM_STEP: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_SUM && r_q.len <= LEN_MAX && r_q.idx < r_q.len
    |=> r_q.acc == $past(r_q.acc) + $past(r_q.pay[r_q.idx[6:0]]))
    else $error("payload byte not added to the sum");

  AST_CSUM_GOOD: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_SUM && r_q.len <= LEN_MAX && r_q.idx >= r_q.len
      && (r_q.acc ^ CSUM_INVERT) == r_q.csum
    |=> r_q.state == ST_EXEC)
    else $error("matching checksum not accepted");

  AST_REMAP_ONLY: assert property (@(posedge clk) disable iff (rst)
    remapRestart |-> r_q.cmd == CMD_REMAP_RESTART && r_q.len == LEN_REMAP)
    else $error("restart without a valid remap command");

  AST_REMAP_PULSE: assert property (@(posedge clk) disable iff (rst)
    remapRestart |=> !remapRestart)
    else $error("restart request longer than one cycle");

  AST_SEED_ONLY: assert property (@(posedge clk) disable iff (rst)
    seedLoad |-> r_q.cmd == CMD_DOWNLOAD_INIT && r_q.len == LEN_SEED)
    else $error("seed pulse without a valid seed command");

  AST_WRITE_ONLY: assert property (@(posedge clk) disable iff (rst)
    memWrEn |-> r_q.state == ST_WRITE && r_q.cmd == CMD_MEM_WRITE)
    else $error("memory write outside a write command");

  AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_IDLE |=> !memWrEn && !seedLoad)
    else $error("side effect while idle");

  AST_WRITE_DONE: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_WRITE && r_q.idx >= r_q.len
    |=> r_q.state == ST_IDLE && r_q.status == STAT_OK && !memWrEn)
    else $error("memory write did not finish");

  AST_PTR_HOLD: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_IDLE |=> r_q.ptr == $past(r_q.ptr))
    else $error("pointer moved between commands");

  AST_HIDDEN_WRITE: assert property (@(posedge clk) disable iff (rst)
    regWrite && !bootMode
    |=> r_q.cmd == $past(r_q.cmd) && r_q.len == $past(r_q.len) && r_q.csum == $past(r_q.csum))
    else $error("write accepted outside boot mode");

  AST_CSUM_SKIP: assert property (@(posedge clk) disable iff (rst)
    r_q.state == ST_SUM |=> !seedLoad && !remapRestart && !memWrEn)
    else $error("side effect before the checksum was checked");

endmodule

`default_nettype wire

// file: rtl/bdcp_pkg.sv
// bdcp_pkg: register map, command codes, status codes and state type of the boot command port
// assumes: byte-wide register access with 8-bit addresses
package bdcp_pkg;

  // register map
  localparam logic [7:0] ADDR_CMD_STAT = 8'h08;
  localparam logic [7:0] ADDR_LENGTH = 8'h09;
  localparam logic [7:0] ADDR_PAY_BASE = 8'h0A;
  localparam logic [7:0] ADDR_PAY_END = 8'h8A;
  localparam logic [7:0] ADDR_CHECKSUM = 8'h8B;
  localparam int PAY_BYTES = 128;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_PTR = 16'h0000;

  // the register set is visible only under this running application identifier
  localparam logic [7:0] BOOT_APP_ID = 8'h80;

  // command codes
  localparam logic [7:0] CMD_REMAP_RESTART = 8'h11;
  localparam logic [7:0] CMD_DOWNLOAD_INIT = 8'h14;
  localparam logic [7:0] CMD_MEM_WRITE = 8'h41;
  localparam logic [7:0] CMD_PTR_SET = 8'h43;

  // payload lengths required per command, and the maximum length for any command
  localparam logic [7:0] LEN_REMAP = 8'h00;
  localparam logic [7:0] LEN_SEED = 8'h01;
  localparam logic [7:0] LEN_PTR = 8'h02;
  localparam logic [7:0] LEN_MAX = 8'h80;

  // checksum inversion mask
  localparam logic [7:0] CSUM_INVERT = 8'hFF;

  // status codes, anything but zero or busy is an error
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_BUSY = 8'h01;
  localparam logic [7:0] STAT_CSUM_ERR = 8'h02;
  localparam logic [7:0] STAT_CMD_ERR = 8'h03;
  localparam logic [7:0] STAT_LEN_ERR = 8'h04;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SUM,
    ST_EXEC,
    ST_WRITE
  } bdcp_state_t;

  typedef struct packed {
    bdcp_state_t state;
    logic [7:0] cmd;
    logic [7:0] len;
    logic [7:0] csum;
    logic [7:0] status;
    logic [PAY_BYTES-1:0][7:0] pay;
    logic [15:0] ptr;
    logic [7:0] idx;
    logic [7:0] acc;
    logic [7:0] rdData;
    logic memWrEn;
    logic [15:0] memAddr;
    logic [7:0] memWrData;
    logic seedLoad;
    logic [7:0] seedValue;
    logic remapRestart;
  } bdcp_regs_t;

endpackage

// file: verification/bdcp_host_model.sv
// bdcp_host_model: host processor side of the boot command register port
// assumes: strobes taken on rising clk, read data valid the cycle after the read edge
`timescale 1ns/10ps
`default_nettype none
module bdcp_host_model
  import bdcp_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic [7:0] regWrData,
  output logic regRead,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWrData = 8'h00;
    regRead = 1'b0;
  end
  // released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge clk);
    d = regRdData;
  endtask
  // payload, length and checksum first, command last; bad spoils the checksum
  task automatic issue(input logic [7:0] c, input logic [7:0] n, input logic [7:0] p [128],
                       input logic bad);
    logic [7:0] s;
    s = c + n;
    for (int k = 0; k < n && k < 128; k++) begin
      wr(ADDR_PAY_BASE + k[7:0], p[k]);
      s = s + p[k];
    end
    wr(ADDR_LENGTH, n);
    wr(ADDR_CHECKSUM, s ^ 8'hFF ^ {7'h00, bad});
    wr(ADDR_CMD_STAT, c);
  endtask
endmodule
`default_nettype wire

// file: verification/bdcp_bench.sv
// bdcp_bench: self-checking bench of the boot command port
// assumes: bdcp_core with the host model on its register port
`timescale 1ns/10ps
`default_nettype none
module bdcp_bench;
  import bdcp_pkg::*;
  typedef struct packed {logic [7:0] c, n, b0, b1, b2; logic bad; logic [7:0] st;} bdcp_row_t;
  localparam bdcp_row_t ROWS [11] = '{
    '{8'h43, 8'h02, 8'h34, 8'h12, 8'h00, 1'b0, 8'h00},
    '{8'h41, 8'h03, 8'hA1, 8'hA2, 8'hA3, 1'b0, 8'h00},
    '{8'h41, 8'h01, 8'hB4, 8'h00, 8'h00, 1'b0, 8'h00},
    '{8'h14, 8'h01, 8'h5A, 8'h00, 8'h00, 1'b0, 8'h00},
    '{8'h43, 8'h02, 8'h00, 8'h20, 8'h00, 1'b1, 8'h02},
    '{8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h03},
    '{8'h43, 8'h01, 8'h00, 8'h00, 8'h00, 1'b0, 8'h04},
    '{8'h41, 8'h81, 8'h00, 8'h00, 8'h00, 1'b0, 8'h04},
    '{8'h14, 8'h02, 8'h66, 8'h01, 8'h00, 1'b0, 8'h04},
    '{8'h11, 8'h01, 8'h9C, 8'h00, 8'h00, 1'b0, 8'h04},
    '{8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}};
  localparam logic [7:0] RADDR [6] = '{8'h08, 8'h09, 8'h0A, 8'h89, 8'h8B, 8'h8A};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] appId = BOOT_APP_ID;
  logic [7:0] regAddr, regWrData, regRdData, seedValue, memWrData;
  logic regWrite, regRead, memWrEn, seedLoad, remapRestart;
  logic [15:0] memAddr;
  logic [15:0] memBase = 16'h0000;
  logic [15:0] lastAddr = 16'h0000;
  int memWrites = 0;
  int memMark = 0;
  logic [7:0] pay [128];
  logic [7:0] expQ [$];
  int bad_count = 0;
  int samples_checked = 0;
  int seeds = 0;
  int remaps = 0;
  int cyc = 0;
  int cmdCyc = 0;
  always #25 clk = ~clk;
  bdcp_core u_dut (.clk(clk), .rst(rst), .appId(appId), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
    .memWrEn(memWrEn), .memAddr(memAddr), .memWrData(memWrData), .seedLoad(seedLoad),
    .seedValue(seedValue), .remapRestart(remapRestart));
  bdcp_host_model u_host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
    .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic poll(output logic [7:0] s);
    for (int t = 0; t < 300; t++) begin
      u_host.rd(ADDR_CMD_STAT, s);
      if (s !== STAT_BUSY) return;
    end
    chk("pollTimeout", 16'h0001, 16'h0000);
    close_out();
  endtask
  // output monitor
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (regWrite && regAddr == ADDR_CMD_STAT) cmdCyc <= cyc;
    if (seedLoad) begin
      seeds <= seeds + 1;
      chk("seed", {8'h00, seedValue}, 16'h005A);
    end
    if (remapRestart) begin
      remaps <= remaps + 1;
      chk("remapDelay", 16'(cyc - cmdCyc), 16'h0003);
    end
    if (memWrEn) begin
      chk("memAddr", memAddr, memBase + 16'(memWrites - memMark));
      chk("memData", {8'h00, memWrData}, {8'h00, expQ.pop_front()});
      memWrites <= memWrites + 1;
      lastAddr <= memAddr;
    end
  end
  initial begin
    bdcp_row_t r;
    logic [7:0] v;
    foreach (pay[k]) pay[k] = 8'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (RADDR[i]) begin
      u_host.rd(RADDR[i], v);
      chk("resetValue", {8'h00, v}, 16'h0000);
    end
    u_host.wr(8'h89, 8'h77);
    u_host.rd(8'h89, v);
    chk("payLast", {8'h00, v}, 16'h0077);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      pay[0] = r.b0;
      pay[1] = r.b1;
      pay[2] = r.b2;
      if (r.c == CMD_MEM_WRITE && r.st == STAT_OK) begin
        for (int k = 0; k < r.n; k++) expQ.push_back(pay[k]);
      end
      u_host.issue(r.c, r.n, pay, r.bad);
      poll(v);
      chk("status", {8'h00, v}, {8'h00, r.st});
      chk("memLeft", 16'(expQ.size()), 16'h0000);
      if (r.c == CMD_PTR_SET && r.st == STAT_OK) begin
        memBase = {r.b1, r.b0};
        memMark = memWrites;
      end
    end
    chk("seedCount", 16'(seeds), 16'h0001);
    chk("remapCount", 16'(remaps), 16'h0001);
    // a hardware reset brings the port back after a restart
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    u_host.rd(ADDR_CHECKSUM, v);
    chk("rerunChecksum", {8'h00, v}, 16'h0000);
    u_host.rd(ADDR_PAY_BASE, v);
    chk("rerunPayload", {8'h00, v}, 16'h0000);
    chk("rerunSeed", {8'h00, seedValue}, 16'h0000);
    // full window write ending on a page boundary
    pay[0] = 8'h80;
    pay[1] = 8'h0F;
    u_host.issue(CMD_PTR_SET, LEN_PTR, pay, 1'b0);
    poll(v);
    memBase = 16'h0F80;
    memMark = memWrites;
    for (int k = 0; k < 128; k++) begin
      pay[k] = k[7:0] ^ 8'h5C;
      expQ.push_back(pay[k]);
    end
    u_host.issue(CMD_MEM_WRITE, LEN_MAX, pay, 1'b0);
    poll(v);
    chk("fullStatus", {8'h00, v}, 16'h0000);
    chk("fullLeft", 16'(expQ.size()), 16'h0000);
    pay[0] = 8'hC3;
    expQ.push_back(8'hC3);
    u_host.issue(CMD_MEM_WRITE, 8'h01, pay, 1'b0);
    poll(v);
    chk("fullNext", lastAddr, 16'h1000);
    @(posedge clk);
    appId <= 8'h00;
    u_host.wr(ADDR_LENGTH, 8'h55);
    u_host.rd(ADDR_LENGTH, v);
    chk("hiddenRead", {8'h00, v}, 16'h0000);
    @(posedge clk);
    appId <= BOOT_APP_ID;
    u_host.rd(ADDR_LENGTH, v);
    chk("hiddenWrite", {8'h00, v}, 16'h0001);
    close_out();
  end
endmodule
`default_nettype wire
